// file: hdl/astr_pkg.sv
// Constants shared by the audio serial task, event and interrupt register block.
// Assumes a 32-bit APB register port with byte addresses.
package astr_pkg;
    localparam logic [11:0] TASK_START_OFS = 12'h000;
    localparam logic [11:0] TASK_STOP_OFS = 12'h004;
    localparam logic [11:0] START_SUB_OFS = 12'h080;
    localparam logic [11:0] STOP_SUB_OFS = 12'h084;
    localparam logic [11:0] RX_FLAG_OFS = 12'h104;
    localparam logic [11:0] HALT_FLAG_OFS = 12'h108;
    localparam logic [11:0] TX_FLAG_OFS = 12'h114;
    localparam logic [11:0] RX_PUB_OFS = 12'h184;
    localparam logic [11:0] HALT_PUB_OFS = 12'h188;
    localparam logic [11:0] TX_PUB_OFS = 12'h194;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h300;
    localparam int CH_IDX_LSB = 0;
    localparam int CH_IDX_W = 4;
    localparam int CH_EN_BIT = 31;
    localparam int IRQ_RX_BIT = 1;
    localparam int IRQ_HALT_BIT = 2;
    localparam int IRQ_TX_BIT = 5;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int NUM_CHANNELS = 16;
endpackage

// file: hdl/astr_task_event_regs.sv
// Task, event, subscribe/publish and interrupt-enable registers of an audio serial port.
// Assumes an APB master on clk, event channels as one-cycle pulses on clk, and the
// serial word clock arriving from a pin outside the clk domain.
//
// Summary of operation
// - Start subscription holds channel and enable; selected channel event starts transfer.
// - Stop subscription holds channel and enable; selected channel event stops transfer.
// - Receive update flag sets when receive buffer start is latched.
// - While started with receive enabled, receive update fires every buffer-size words.
// - Transmit update flag sets when transmit buffer start is latched.
// - While started with transmit enabled, transmit update fires every buffer-size words.
// - Halted flag sets when the transfer has come to a stop.
// - Receive update publish register drives each receive update onto its channel.
// - Halted publish register drives each halted event onto its channel.
// - Transmit update publish register drives each transmit update onto its channel.
// - Interrupt mask bit one gates the receive update event into the interrupt.
// - Interrupt mask bit two gates the halted event into the interrupt.
// - Interrupt mask bit five gates the transmit update event into the interrupt.
// - Start task begins transfer and runs master clock when its generator is enabled.
// - Stop task halts transfer and master clock, then raises the halted event.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module astr_task_event_regs #(
    parameter int WCNT_W = 14
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [astr_pkg::NUM_CHANNELS-1:0] chanEventIn,
    output logic [astr_pkg::NUM_CHANNELS-1:0] chanEventOut,
    input wire logic rxEnable,
    input wire logic txEnable,
    input wire logic mckGenEnable,
    input wire logic [WCNT_W-1:0] bufferWordCount,
    input wire logic wordClkPin,
    output logic transferRunning,
    output logic masterClockRun,
    output logic rxBufferLatch,
    output logic txBufferLatch,
    output logic irq
);
    logic [31:0] startSub_q, stopSub_q, rxPub_q, haltPub_q, txPub_q, irqMask_q;
    logic rxFlag_q, haltFlag_q, txFlag_q;
    logic running_q, stopPending_q;
    logic wordSync1_q, wordSync2_q, wordPrev_q;
    logic [WCNT_W-1:0] rxCnt_q, txCnt_q;
    logic rxEvent_q, txEvent_q, haltEvent_q;
    logic [31:0] prdata_q;
    logic slvErr_q;
    logic wrAcc, rdSetup, mapped, wordEdge;
    logic startTask, stopTask;

    assign wrAcc = psel && penable && pwrite;
    assign rdSetup = psel && !penable;

    always_comb begin
        if (paddr == astr_pkg::TASK_START_OFS || paddr == astr_pkg::TASK_STOP_OFS) begin
            mapped = 1'b1;
        end else if (paddr == astr_pkg::START_SUB_OFS || paddr == astr_pkg::STOP_SUB_OFS) begin
            mapped = 1'b1;
        end else if (paddr == astr_pkg::RX_FLAG_OFS || paddr == astr_pkg::HALT_FLAG_OFS) begin
            mapped = 1'b1;
        end else if (paddr == astr_pkg::TX_FLAG_OFS || paddr == astr_pkg::RX_PUB_OFS) begin
            mapped = 1'b1;
        end else if (paddr == astr_pkg::HALT_PUB_OFS || paddr == astr_pkg::TX_PUB_OFS) begin
            mapped = 1'b1;
        end else if (paddr == astr_pkg::IRQ_MASK_OFS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // A subscribed channel and a software task write both trigger; they may coincide.
    // start and stop task triggers
    assign startTask = (wrAcc && paddr == astr_pkg::TASK_START_OFS && pwdata[0])
        || (startSub_q[astr_pkg::CH_EN_BIT]
        && chanEventIn[startSub_q[astr_pkg::CH_IDX_LSB +: astr_pkg::CH_IDX_W]]);
    assign stopTask = (wrAcc && paddr == astr_pkg::TASK_STOP_OFS && pwdata[0])
        || (stopSub_q[astr_pkg::CH_EN_BIT]
        && chanEventIn[stopSub_q[astr_pkg::CH_IDX_LSB +: astr_pkg::CH_IDX_W]]);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            startSub_q <= astr_pkg::REG_RESET;
            stopSub_q <= astr_pkg::REG_RESET;
            rxPub_q <= astr_pkg::REG_RESET;
            haltPub_q <= astr_pkg::REG_RESET;
            txPub_q <= astr_pkg::REG_RESET;
            irqMask_q <= astr_pkg::REG_RESET;
        end else if (wrAcc) begin
            if (paddr == astr_pkg::START_SUB_OFS) begin
                startSub_q <= pwdata & 32'h8000_000f;
            end else if (paddr == astr_pkg::STOP_SUB_OFS) begin
                stopSub_q <= pwdata & 32'h8000_000f;
            end else if (paddr == astr_pkg::RX_PUB_OFS) begin
                rxPub_q <= pwdata & 32'h8000_000f;
            end else if (paddr == astr_pkg::HALT_PUB_OFS) begin
                haltPub_q <= pwdata & 32'h8000_000f;
            end else if (paddr == astr_pkg::TX_PUB_OFS) begin
                txPub_q <= pwdata & 32'h8000_000f;
            end else if (paddr == astr_pkg::IRQ_MASK_OFS) begin
                irqMask_q <= pwdata & 32'h0000_0026;
            end
        end
    end

    // Stop wins over a start in the same cycle so software can always halt the port.
    // start begins transfer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            running_q <= 1'b0;
            stopPending_q <= 1'b0;
        end else begin
            if (stopTask) begin
                running_q <= 1'b0;
            end else if (startTask) begin
                running_q <= 1'b1;
            end
            stopPending_q <= stopTask;
        end
    end

    assign transferRunning = running_q;
    assign masterClockRun = running_q && mckGenEnable;

    // The first stage feeds only the second; edges are found on the settled copy.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wordSync1_q <= 1'b0;
            wordSync2_q <= 1'b0;
            wordPrev_q <= 1'b0;
        end else begin
            wordSync1_q <= wordClkPin;
            wordSync2_q <= wordSync1_q;
            wordPrev_q <= wordSync2_q;
        end
    end

    // Every word clock edge closes one word on each active direction.
    assign wordEdge = wordSync2_q != wordPrev_q;

    // The buffer start is latched on start and again after each full buffer of words.
    // receive word counting
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxCnt_q <= '0;
            rxEvent_q <= 1'b0;
        end else if (!(running_q && rxEnable)) begin
            rxCnt_q <= '0;
            rxEvent_q <= startTask && !stopTask && !running_q && rxEnable;
        end else if (wordEdge && rxCnt_q + WCNT_W'(1) >= bufferWordCount) begin
            rxCnt_q <= '0;
            rxEvent_q <= 1'b1;
        end else begin
            rxCnt_q <= wordEdge ? rxCnt_q + WCNT_W'(1) : rxCnt_q;
            rxEvent_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txCnt_q <= '0;
            txEvent_q <= 1'b0;
        end else if (!(running_q && txEnable)) begin
            txCnt_q <= '0;
            txEvent_q <= startTask && !stopTask && !running_q && txEnable;
        end else if (wordEdge && txCnt_q + WCNT_W'(1) >= bufferWordCount) begin
            txCnt_q <= '0;
            txEvent_q <= 1'b1;
        end else begin
            txCnt_q <= wordEdge ? txCnt_q + WCNT_W'(1) : txCnt_q;
            txEvent_q <= 1'b0;
        end
    end

    assign rxBufferLatch = rxEvent_q;
    assign txBufferLatch = txEvent_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            haltEvent_q <= 1'b0;
        end else begin
            haltEvent_q <= stopPending_q;
        end
    end

    // A hardware set in the same cycle as a software clear keeps the flag set.
    // sticky flags
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxFlag_q <= 1'b0;
            haltFlag_q <= 1'b0;
            txFlag_q <= 1'b0;
        end else begin
            if (rxEvent_q) begin
                rxFlag_q <= 1'b1;
            end else if (wrAcc && paddr == astr_pkg::RX_FLAG_OFS && !pwdata[0]) begin
                rxFlag_q <= 1'b0;
            end
            if (haltEvent_q) begin
                haltFlag_q <= 1'b1;
            end else if (wrAcc && paddr == astr_pkg::HALT_FLAG_OFS && !pwdata[0]) begin
                haltFlag_q <= 1'b0;
            end
            if (txEvent_q) begin
                txFlag_q <= 1'b1;
            end else if (wrAcc && paddr == astr_pkg::TX_FLAG_OFS && !pwdata[0]) begin
                txFlag_q <= 1'b0;
            end
        end
    end

    // Publish channels are ORed, so two events on one channel merge into one pulse.
    // receive, halted and transmit publish
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chanEventOut <= '0;
        end else begin
            for (int c = 0; c < astr_pkg::NUM_CHANNELS; c++) begin
                chanEventOut[c] <= (rxEvent_q && rxPub_q[astr_pkg::CH_EN_BIT]
                    && rxPub_q[astr_pkg::CH_IDX_W-1:0] == c[astr_pkg::CH_IDX_W-1:0])
                    || (haltEvent_q && haltPub_q[astr_pkg::CH_EN_BIT]
                    && haltPub_q[astr_pkg::CH_IDX_W-1:0] == c[astr_pkg::CH_IDX_W-1:0])
                    || (txEvent_q && txPub_q[astr_pkg::CH_EN_BIT]
                    && txPub_q[astr_pkg::CH_IDX_W-1:0] == c[astr_pkg::CH_IDX_W-1:0]);
            end
        end
    end

    assign irq = (rxFlag_q && irqMask_q[astr_pkg::IRQ_RX_BIT])
        || (haltFlag_q && irqMask_q[astr_pkg::IRQ_HALT_BIT])
        || (txFlag_q && irqMask_q[astr_pkg::IRQ_TX_BIT]);

    // Read data is captured in the setup cycle so the access phase answers at once.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= astr_pkg::REG_RESET;
            slvErr_q <= 1'b0;
        end else if (rdSetup) begin
            slvErr_q <= !mapped;
            if (pwrite) begin
                prdata_q <= '0;
            end else if (paddr == astr_pkg::START_SUB_OFS) begin
                prdata_q <= startSub_q;
            end else if (paddr == astr_pkg::STOP_SUB_OFS) begin
                prdata_q <= stopSub_q;
            end else if (paddr == astr_pkg::RX_FLAG_OFS) begin
                prdata_q <= {31'h0, rxFlag_q};
            end else if (paddr == astr_pkg::HALT_FLAG_OFS) begin
                prdata_q <= {31'h0, haltFlag_q};
            end else if (paddr == astr_pkg::TX_FLAG_OFS) begin
                prdata_q <= {31'h0, txFlag_q};
            end else if (paddr == astr_pkg::RX_PUB_OFS) begin
                prdata_q <= rxPub_q;
            end else if (paddr == astr_pkg::HALT_PUB_OFS) begin
                prdata_q <= haltPub_q;
            end else if (paddr == astr_pkg::TX_PUB_OFS) begin
                prdata_q <= txPub_q;
            end else if (paddr == astr_pkg::IRQ_MASK_OFS) begin
                prdata_q <= irqMask_q;
            end else begin
                prdata_q <= '0;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && slvErr_q;
endmodule // astr_task_event_regs

// file: test/astr_event_partner.sv
// Model of the event channel fabric and of the serial word clock pin.
// Assumes one-cycle channel pulses on clk; word edges run on an unrelated phase.
`timescale 1ns/1ns
module astr_event_partner (
    input wire logic clk,
    output logic [15:0] chanEventIn,
    output logic wordClkPin
);
    initial begin
        chanEventIn = 16'h0;
        wordClkPin = 1'h0;
    end
    task automatic pulse(input logic [3:0] ch);
        @(posedge clk);
        chanEventIn <= 16'h1 << ch;
        @(posedge clk);
        chanEventIn <= 16'h0;
    endtask
    // The word clock moves only while words are sent, so counts stay exact.
    // Returns just after the last edge, so the caller can still catch the event it causes.
    task automatic words(input int n);
        #3;
        wordClkPin = ~wordClkPin;
        repeat (n - 1) begin
            #80;
            wordClkPin = ~wordClkPin;
        end
    endtask
endmodule // astr_event_partner

// file: test/astr_task_event_props.sv
// Port-level assertions for the audio serial task and event register block.
// Assumes a single clk domain; bound to every instance of the block below.
`timescale 1ns/1ns
module astr_task_event_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [15:0] chanEventIn,
    input wire logic [15:0] chanEventOut,
    input wire logic rxEnable,
    input wire logic txEnable,
    input wire logic mckGenEnable,
    input wire logic transferRunning,
    input wire logic masterClockRun,
    input wire logic rxBufferLatch,
    input wire logic txBufferLatch,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic apbWr;
    assign apbWr = psel && penable && pwrite;
    chk_start_runs: assert property (apbWr && paddr == astr_pkg::TASK_START_OFS && pwdata[0]
        && chanEventIn == 16'h0 |=> transferRunning) else $error("start task ignored");
    chk_stop_halts: assert property (apbWr && paddr == astr_pkg::TASK_STOP_OFS && pwdata[0]
        |=> !transferRunning) else $error("stop task ignored");
    chk_mck_follows: assert property (masterClockRun == (transferRunning && mckGenEnable))
        else $error("master clock run wrong");
    chk_latch_on_start: assert property ($rose(transferRunning) && rxEnable && txEnable
        |-> rxBufferLatch && txBufferLatch) else $error("no pointer latch at start");
    chk_idle_no_latch: assert property (!transferRunning [*3]
        |-> !rxBufferLatch && !txBufferLatch) else $error("latch while stopped");
    chk_pub_pulse: assert property (chanEventOut != 16'h0 |=> chanEventOut == 16'h0)
        else $error("publish pulse too long");
    chk_mask_zero: assert property (apbWr && paddr == astr_pkg::IRQ_MASK_OFS
        && pwdata == 32'h0 |=> !irq) else $error("irq with empty mask");
    chk_mask_bits: assert property (psel && penable && !pwrite
        && paddr == astr_pkg::IRQ_MASK_OFS |-> (prdata & ~32'h26) == 32'h0)
        else $error("mask reserved bits set");
endmodule // astr_task_event_props

bind astr_task_event_regs astr_task_event_props props (.clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .chanEventIn, .chanEventOut, .rxEnable, .txEnable,
    .mckGenEnable, .transferRunning, .masterClockRun, .rxBufferLatch, .txBufferLatch, .irq);

// file: test/tb_audio_serial_task_event_regs.sv
// Self-checking bench for the audio serial task and event register block.
// Assumes the partner model supplies channel pulses and word clock edges.
`timescale 1ns/1ns
module tb_audio_serial_task_event_regs;
    typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} astr_row_t;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic rxEnable = 1, txEnable = 1, mckGenEnable = 1;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, wordClkPin, transferRunning, masterClockRun, irq;
    logic rxBufferLatch, txBufferLatch;
    logic [13:0] bufferWordCount = 14'h0003;
    logic [15:0] chanEventIn, chanEventOut;
    int mismatches = 0, total_checks = 0;
    astr_row_t rows [8] = '{
        '{astr_pkg::START_SUB_OFS, 32'hfffffff5, 32'h80000005, 1'h0},
        '{astr_pkg::STOP_SUB_OFS, 32'h8000fffa, 32'h8000000a, 1'h0},
        '{astr_pkg::RX_PUB_OFS, 32'h80000003, 32'h80000003, 1'h0},
        '{astr_pkg::HALT_PUB_OFS, 32'h8000000c, 32'h8000000c, 1'h0},
        '{astr_pkg::TX_PUB_OFS, 32'hfffffff7, 32'h80000007, 1'h0},
        '{astr_pkg::IRQ_MASK_OFS, 32'hffffffff, 32'h00000026, 1'h0},
        '{astr_pkg::TASK_START_OFS, 32'h0, 32'h0, 1'h0},
        '{12'h200, 32'hffffffff, 32'h0, 1'h1}};
    astr_task_event_regs #(.WCNT_W(14)) dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .chanEventIn, .chanEventOut, .rxEnable,
        .txEnable, .mckGenEnable, .bufferWordCount, .wordClkPin, .transferRunning,
        .masterClockRun, .rxBufferLatch, .txBufferLatch, .irq);
    astr_event_partner partner (.clk, .chanEventIn, .wordClkPin);
    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic fail();
        mismatches++;
        end_of_test();
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'h1) break;
            if (i == 49) fail();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_out(input logic [15:0] m);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if ((chanEventOut & m) != 16'h0) begin
                chk({16'h0, chanEventOut}, {16'h0, m});
                return;
            end
        end
        fail();
    endtask
    task automatic irq_for(input logic [31:0] m, input logic e);
        apb(astr_pkg::IRQ_MASK_OFS, 1'h1, m);
        #1 chk({31'h0, irq}, {31'h0, e});
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].a, 1'h1, rows[i].w);
            apb(rows[i].a, 1'h0, 32'h0);
            chk({31'h0, er}, {31'h0, rows[i].e});
            chk(rd, rows[i].r);
        end
        partner.pulse(4'h5);
        wait_out(16'h0088);
        chk({30'h0, transferRunning, masterClockRun}, 32'h3);
        apb(astr_pkg::RX_FLAG_OFS, 1'h0, 32'h0);
        chk(rd, 32'h1);
        apb(astr_pkg::TX_FLAG_OFS, 1'h0, 32'h0);
        chk(rd, 32'h1);
        irq_for(32'h0, 1'h0);
        irq_for(32'h2, 1'h1);
        irq_for(32'h20, 1'h1);
        apb(astr_pkg::RX_FLAG_OFS, 1'h1, 32'h0);
        apb(astr_pkg::TX_FLAG_OFS, 1'h1, 32'h0);
        irq_for(32'h26, 1'h0);
        partner.words(2);
        repeat (10) @(posedge clk);
        apb(astr_pkg::RX_FLAG_OFS, 1'h0, 32'h0);
        chk(rd, 32'h0);
        partner.words(1);
        wait_out(16'h0088);
        apb(astr_pkg::TASK_STOP_OFS, 1'h1, 32'h1);
        wait_out(16'h1000);
        chk({30'h0, transferRunning, masterClockRun}, 32'h0);
        apb(astr_pkg::HALT_FLAG_OFS, 1'h0, 32'h0);
        chk(rd, 32'h1);
        irq_for(32'h4, 1'h1);
        apb(astr_pkg::TASK_START_OFS, 1'h1, 32'h1);
        wait_out(16'h0088);
        @(posedge clk);
        mckGenEnable <= 1'h0;
        @(posedge clk);
        #1 chk({30'h0, transferRunning, masterClockRun}, 32'h2);
        partner.pulse(4'ha);
        wait_out(16'h1000);
        @(posedge clk);
        rst_b <= 1'h0;
        @(posedge clk);
        rst_b <= 1'h1;
        foreach (rows[i]) begin
            apb(rows[i].a, 1'h0, 32'h0);
            chk(rd, 32'h0);
        end
        end_of_test();
    end
endmodule // tb_audio_serial_task_event_regs
